// [pkg/bts_pkg.sv]
package bts_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TICK_HZ = 1000000;
  localparam int unsigned CYC_PER_TICK = CLK_HZ / TICK_HZ;
  localparam int unsigned SECOND_US = 1000000;
  localparam int unsigned RESET_MIN_MS = 700;
  localparam int unsigned RESET_MIN_US = RESET_MIN_MS * 1000;
  localparam int unsigned TOPPING_S = 7200;
  localparam int unsigned HISTORY_S = 60;
  localparam int unsigned PROBE_US = 16;

  // Sample format: millivolts at the temperature-sense input
  localparam int unsigned MV_W = 13;
  localparam logic [12:0] HOT_MV = 13'h03a2;
  localparam logic [12:0] COLD_MV = 13'h0960;
  localparam logic [12:0] SWITCH_OPEN_MV = 13'h1068;
  localparam logic [12:0] SLOPE_FAST_MV = 13'h0028;
  localparam logic [12:0] SLOPE_HALF_MV = 13'h001c;

  // Synchroniser bit positions and reset levels
  localparam int unsigned SYNC_W = 6;
  localparam int unsigned SY_MRST = 0;
  localparam int unsigned SY_TSEL = 1;
  localparam int unsigned SY_CMI = 2;
  localparam int unsigned SY_RATE0 = 3;
  localparam int unsigned SY_RATE1 = 4;
  localparam int unsigned SY_SWMODE = 5;
  localparam logic [5:0] SYNC_RST = 6'h01;

  typedef enum logic [6:0] {
    BTS_CAPTURE = 7'h01,
    BTS_WATCH = 7'h02,
    BTS_TOPPING = 7'h04,
    BTS_MAINT = 7'h08,
    BTS_FAST = 7'h10,
    BTS_DONE = 7'h20,
    BTS_SHUTDOWN = 7'h40
  } bts_state_t;
endpackage

// [pkg/bts_mem_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface bts_mem_if #(parameter int unsigned AW = 6, parameter int unsigned DW = 13);
  logic wrEn;
  logic [AW-1:0] addr;
  logic [DW-1:0] wrData;
  logic [DW-1:0] rdData;
  modport user (output wrEn, output addr, output wrData, input rdData);
  modport mem (input wrEn, input addr, input wrData, output rdData);
endinterface
`default_nettype wire

// [hdl/bts_history_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module bts_history_mem #(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW = 6,
  parameter int unsigned DW = 13
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  bts_mem_if.mem port
);
  logic [DW-1:0] store [DEPTH];
  logic [DW-1:0] rdData_ff;

  // Array has no reset; entries are only read once written
  always_ff @(posedge clk_sys) begin
    if (port.wrEn) begin
      store[port.addr] <= port.wrData;
    end
  end

  // Registered read returns the old word on a same-address write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdData_ff <= '0;
    end else begin
      rdData_ff <= store[port.addr];
    end
  end

  assign port.rdData = rdData_ff;
endmodule
`default_nettype wire

// [hdl/bts_supervisor.sv]
// How it works
// - All timing from a 1 MHz tick.
// - Thermistor and switch modes use separate thresholds.
// - Below 0.93 V latches hot-battery shutdown.
// - Shutdown holds until master reset.
// - Above 2.4 V before fast: cold charge.
// - Temperature slope measured per minute during fast.
// - Threshold 40 mV/min, 28 mV/min at C/2.
// - Slope at or above threshold ends fast charge.
// - Two-hour topping, then maintenance while cold.
// - Recheck each second; warm starts fast charge.
// - Termination select sampled after reset, three settings.
// - Switch mode above 4.2 V latches shutdown.
`timescale 1ns/1ps
`default_nettype none
module bts_supervisor #(
  parameter int unsigned SECOND_CYC = bts_pkg::SECOND_US,
  parameter int unsigned RESET_CYC = bts_pkg::RESET_MIN_US,
  parameter int unsigned TOPPING_SEC = bts_pkg::TOPPING_S,
  parameter int unsigned HIST_DEPTH = bts_pkg::HISTORY_S
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sampleValid,
  input wire logic [12:0] sampleMv,
  input wire logic sensorIsSwitch,
  input wire logic master_reset_n,
  input wire logic termination_select,
  input wire logic charge_mode_indicator,
  input wire logic rate_select_0,
  input wire logic rate_select_1,
  input wire logic fastRequest,
  input wire logic fastEnd,
  output logic cmnProbeOut,
  output logic cmnProbeOe,
  output logic hotShutdown,
  output logic coldCharge,
  output logic toppingActive,
  output logic maintActive,
  output logic fastActive,
  output logic startFast,
  output logic slopeTerminate,
  output logic voltSlopeEn,
  output logic tempSlopeEn,
  output logic selectDone
);
  localparam int unsigned TICK_W = 5;
  localparam int unsigned US_W = 20;
  localparam int unsigned SEC_W = 13;
  localparam int unsigned AW = 6;

  bts_mem_if #(.AW(AW), .DW(bts_pkg::MV_W)) hist ();

  bts_history_mem #(.DEPTH(64), .AW(AW), .DW(bts_pkg::MV_W)) u_hist (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .port(hist.mem)
  );

  // Two-flop synchronisers for every pin input
  logic [bts_pkg::SYNC_W-1:0] syncIn;
  logic [bts_pkg::SYNC_W-1:0] sync1_ff;
  logic [bts_pkg::SYNC_W-1:0] sync2_ff;
  assign syncIn = {sensorIsSwitch, rate_select_1, rate_select_0,
                   charge_mode_indicator, termination_select, master_reset_n};
  genvar gi;
  generate
    for (gi = 0; gi < bts_pkg::SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          sync1_ff[gi] <= bts_pkg::SYNC_RST[gi];
          sync2_ff[gi] <= bts_pkg::SYNC_RST[gi];
        end else begin
          sync1_ff[gi] <= syncIn[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  logic mrLow;
  logic isSwitch;
  logic rateHalf;
  assign mrLow = !sync2_ff[bts_pkg::SY_MRST];
  assign isSwitch = sync2_ff[bts_pkg::SY_SWMODE];
  assign rateHalf = sync2_ff[bts_pkg::SY_RATE0] && sync2_ff[bts_pkg::SY_RATE1];

  // Time base: 1 us tick and 1 s tick, so durations follow the clock
  logic [TICK_W-1:0] tickCnt_ff, nxt_tickCnt;
  logic [US_W-1:0] usCnt_ff, nxt_usCnt;
  logic [US_W-1:0] mrCnt_ff, nxt_mrCnt;
  logic usTick;
  logic secTick;
  logic softClr;

  always_comb begin
    usTick = (tickCnt_ff == TICK_W'(bts_pkg::CYC_PER_TICK - 1));
    secTick = usTick && (usCnt_ff == US_W'(SECOND_CYC - 1));
    nxt_tickCnt = usTick ? '0 : tickCnt_ff + 1'b1;
    nxt_usCnt = usCnt_ff;
    if (usTick) begin
      nxt_usCnt = secTick ? '0 : usCnt_ff + 1'b1;
    end
    // Master reset only counts once held low long enough
    nxt_mrCnt = mrCnt_ff;
    if (!mrLow) begin
      nxt_mrCnt = '0;
    end else if (usTick && mrCnt_ff != US_W'(RESET_CYC)) begin
      nxt_mrCnt = mrCnt_ff + 1'b1;
    end
    softClr = (mrCnt_ff == US_W'(RESET_CYC));
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt_ff <= '0;
      usCnt_ff <= '0;
      mrCnt_ff <= '0;
    end else begin
      tickCnt_ff <= nxt_tickCnt;
      usCnt_ff <= nxt_usCnt;
      mrCnt_ff <= nxt_mrCnt;
    end
  end

  // Supervisor control state
  bts_pkg::bts_state_t state_ff, nxt_state;
  logic [12:0] latest_ff, nxt_latest;
  logic haveSample_ff, nxt_haveSample;
  logic [TICK_W-1:0] probeCnt_ff, nxt_probeCnt;
  logic strapHigh_ff, nxt_strapHigh;
  logic voltEn_ff, nxt_voltEn;
  logic tempEn_ff, nxt_tempEn;
  logic [SEC_W-1:0] coldSec_ff, nxt_coldSec;
  logic [AW-1:0] ptr_ff, nxt_ptr;
  logic [AW:0] fill_ff, nxt_fill;
  logic cmpPend_ff, nxt_cmpPend;
  logic [12:0] cmpNew_ff, nxt_cmpNew;
  logic startFast_ff, nxt_startFast;
  logic slopeHit_ff, nxt_slopeHit;
  logic hotNow;
  logic cold;
  logic histOn;
  logic [12:0] thr;
  logic [12:0] drop;

  always_comb begin
    nxt_state = state_ff;
    nxt_latest = sampleValid ? sampleMv : latest_ff;
    nxt_haveSample = haveSample_ff || sampleValid;
    nxt_probeCnt = probeCnt_ff;
    nxt_strapHigh = strapHigh_ff;
    nxt_voltEn = voltEn_ff;
    nxt_tempEn = tempEn_ff;
    nxt_coldSec = coldSec_ff;
    nxt_ptr = ptr_ff;
    nxt_fill = fill_ff;
    nxt_cmpPend = 1'b0;
    nxt_cmpNew = cmpNew_ff;
    nxt_startFast = 1'b0;
    nxt_slopeHit = slopeHit_ff;
    hist.wrEn = 1'b0;
    hist.addr = ptr_ff;
    hist.wrData = latest_ff;
    // Each sensor kind has its own hot threshold
    hotNow = sampleValid && (isSwitch ? (sampleMv > bts_pkg::SWITCH_OPEN_MV)
                                      : (sampleMv < bts_pkg::HOT_MV));
    cold = haveSample_ff && !isSwitch && (latest_ff > bts_pkg::COLD_MV);
    thr = rateHalf ? bts_pkg::SLOPE_HALF_MV : bts_pkg::SLOPE_FAST_MV;
    // NTC voltage falls as the pack heats, so the slope is old minus new
    drop = (hist.rdData > cmpNew_ff) ? hist.rdData - cmpNew_ff : '0;
    histOn = (state_ff == bts_pkg::BTS_FAST) && tempEn_ff && !isSwitch;

    case (state_ff)
      bts_pkg::BTS_CAPTURE: begin
        // Probe the strap with the indicator released, then pulled low
        if (usTick) begin
          nxt_probeCnt = probeCnt_ff + 1'b1;
          if (probeCnt_ff == TICK_W'(bts_pkg::PROBE_US - 1)) begin
            nxt_strapHigh = sync2_ff[bts_pkg::SY_TSEL];
          end
          if (probeCnt_ff == TICK_W'(2 * bts_pkg::PROBE_US - 1)) begin
            nxt_tempEn = strapHigh_ff;
            nxt_voltEn = !(strapHigh_ff && !sync2_ff[bts_pkg::SY_TSEL]);
            nxt_state = bts_pkg::BTS_WATCH;
          end
        end
      end
      bts_pkg::BTS_WATCH: begin
        if (fastRequest) begin
          nxt_coldSec = '0;
          if (cold) begin
            nxt_state = bts_pkg::BTS_TOPPING;
          end else begin
            nxt_state = bts_pkg::BTS_FAST;
            nxt_startFast = 1'b1;
          end
        end
      end
      bts_pkg::BTS_TOPPING: begin
        if (secTick) begin
          nxt_coldSec = coldSec_ff + 1'b1;
          if (!cold) begin
            nxt_state = bts_pkg::BTS_FAST;
            nxt_startFast = 1'b1;
          end else if (coldSec_ff == SEC_W'(TOPPING_SEC - 1)) begin
            nxt_state = bts_pkg::BTS_MAINT;
          end
        end
      end
      bts_pkg::BTS_MAINT: begin
        if (secTick && !cold) begin
          nxt_state = bts_pkg::BTS_FAST;
          nxt_startFast = 1'b1;
        end
      end
      bts_pkg::BTS_FAST: begin
        if (cmpPend_ff && drop >= thr) begin
          nxt_slopeHit = 1'b1;
          nxt_state = bts_pkg::BTS_DONE;
        end else if (fastEnd) begin
          nxt_state = bts_pkg::BTS_DONE;
        end
      end
      bts_pkg::BTS_DONE: begin
        nxt_state = bts_pkg::BTS_DONE;
      end
      bts_pkg::BTS_SHUTDOWN: begin
        nxt_state = bts_pkg::BTS_SHUTDOWN;
      end
      default: begin
        nxt_state = bts_pkg::BTS_CAPTURE;
      end
    endcase

    // One history entry per second; the slot read back is one minute old
    if (histOn && secTick) begin
      hist.wrEn = 1'b1;
      nxt_ptr = (ptr_ff == AW'(HIST_DEPTH - 1)) ? '0 : ptr_ff + 1'b1;
      nxt_cmpNew = latest_ff;
      nxt_cmpPend = (fill_ff == (AW + 1)'(HIST_DEPTH));
      if (fill_ff != (AW + 1)'(HIST_DEPTH)) begin
        nxt_fill = fill_ff + 1'b1;
      end
    end else if (!histOn) begin
      nxt_ptr = '0;
      nxt_fill = '0;
    end

    // Hot fault outranks every state except capture; only a master reset lifts it
    if (hotNow && state_ff != bts_pkg::BTS_CAPTURE) begin
      nxt_state = bts_pkg::BTS_SHUTDOWN;
      nxt_startFast = 1'b0;
    end
    if (softClr) begin
      nxt_state = bts_pkg::BTS_CAPTURE;
      nxt_probeCnt = '0;
      nxt_slopeHit = 1'b0;
      nxt_startFast = 1'b0;
      nxt_haveSample = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= bts_pkg::BTS_CAPTURE;
      latest_ff <= '0;
      haveSample_ff <= 1'b0;
      probeCnt_ff <= '0;
      strapHigh_ff <= 1'b0;
      voltEn_ff <= 1'b1;
      tempEn_ff <= 1'b0;
      coldSec_ff <= '0;
      ptr_ff <= '0;
      fill_ff <= '0;
      cmpPend_ff <= 1'b0;
      cmpNew_ff <= '0;
      startFast_ff <= 1'b0;
      slopeHit_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      latest_ff <= nxt_latest;
      haveSample_ff <= nxt_haveSample;
      probeCnt_ff <= nxt_probeCnt;
      strapHigh_ff <= nxt_strapHigh;
      voltEn_ff <= nxt_voltEn;
      tempEn_ff <= nxt_tempEn;
      coldSec_ff <= nxt_coldSec;
      ptr_ff <= nxt_ptr;
      fill_ff <= nxt_fill;
      cmpPend_ff <= nxt_cmpPend;
      cmpNew_ff <= nxt_cmpNew;
      startFast_ff <= nxt_startFast;
      slopeHit_ff <= nxt_slopeHit;
    end
  end

  // Outputs decode registered state only
  assign cmnProbeOut = 1'b0;
  assign cmnProbeOe = (state_ff == bts_pkg::BTS_CAPTURE) &&
                      (probeCnt_ff >= TICK_W'(bts_pkg::PROBE_US));
  assign hotShutdown = (state_ff == bts_pkg::BTS_SHUTDOWN);
  assign toppingActive = (state_ff == bts_pkg::BTS_TOPPING);
  assign maintActive = (state_ff == bts_pkg::BTS_MAINT);
  assign coldCharge = toppingActive || maintActive;
  assign fastActive = (state_ff == bts_pkg::BTS_FAST);
  assign startFast = startFast_ff;
  assign slopeTerminate = slopeHit_ff;
  assign voltSlopeEn = voltEn_ff;
  assign tempSlopeEn = tempEn_ff;
  assign selectDone = (state_ff != bts_pkg::BTS_CAPTURE);
endmodule
`default_nettype wire

// [sim/bts_checker_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module bts_checker_sva (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sampleValid,
  input wire logic [12:0] sampleMv,
  input wire logic sensorIsSwitch,
  input wire logic master_reset_n,
  input wire logic cmnProbeOe,
  input wire logic hotShutdown,
  input wire logic toppingActive,
  input wire logic maintActive,
  input wire logic fastActive,
  input wire logic startFast,
  input wire logic slopeTerminate,
  input wire logic voltSlopeEn,
  input wire logic tempSlopeEn,
  input wire logic selectDone
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // Faults latch one clock after the reading; capture is excluded
  property p_hot;
    sampleValid && !sensorIsSwitch && sampleMv < bts_pkg::HOT_MV && selectDone |=> hotShutdown;
  endproperty
  a_hot: assert property (p_hot) else $error("hot sample not latched");
  property p_open;
    sampleValid && sensorIsSwitch && sampleMv > bts_pkg::SWITCH_OPEN_MV && selectDone
      |=> hotShutdown;
  endproperty
  a_open: assert property (p_open) else $error("open switch not latched");
  // Only a long master reset may clear the latch
  property p_latch;
    hotShutdown && master_reset_n && $past(master_reset_n, 3) |=> hotShutdown;
  endproperty
  a_latch: assert property (p_latch) else $error("shutdown released");
  property p_stop;
    hotShutdown |-> !fastActive && !toppingActive && !maintActive;
  endproperty
  a_stop: assert property (p_stop) else $error("charging during shutdown");
  property p_start;
    startFast |-> fastActive ##1 !startFast;
  endproperty
  a_start: assert property (p_start) else $error("bad start pulse");
  property p_cold;
    $rose(toppingActive) |-> !sensorIsSwitch && !fastActive;
  endproperty
  a_cold: assert property (p_cold) else $error("bad cold entry");
  property p_maint;
    $rose(maintActive) |-> $past(toppingActive);
  endproperty
  a_maint: assert property (p_maint) else $error("maintenance without topping");
  // Strap decode is frozen once captured and never disables both methods
  property p_strap;
    selectDone && $past(selectDone) |-> $stable({voltSlopeEn, tempSlopeEn})
      && (voltSlopeEn || tempSlopeEn) && !cmnProbeOe;
  endproperty
  a_strap: assert property (p_strap) else $error("strap decode changed");
  property p_term;
    $rose(slopeTerminate) |-> tempSlopeEn && !sensorIsSwitch ##[0:1] !fastActive;
  endproperty
  a_term: assert property (p_term) else $error("bad slope end");
endmodule
bind bts_supervisor bts_checker_sva u_chk (.clk_sys, .rst_b, .sampleValid, .sampleMv,
  .sensorIsSwitch, .master_reset_n, .cmnProbeOe, .hotShutdown, .toppingActive, .maintActive,
  .fastActive, .startFast, .slopeTerminate, .voltSlopeEn, .tempSlopeEn, .selectDone);
`default_nettype wire

// [sim/bts_sensor_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bts_sensor_model (
  input wire logic clk_sys,
  input wire logic [12:0] tempMv,
  input wire logic [1:0] strapMode,
  input wire logic cmnProbeOe,
  input wire logic cmnProbeOut,
  output logic chargeModeNet,
  output logic strapLevel,
  output logic sampleValid,
  output logic [12:0] sampleMv
);
  logic [3:0] divCnt = 4'h0;
  // Indicator net has an external pull-up unless the device sinks it
  assign chargeModeNet = cmnProbeOe ? cmnProbeOut : 1'b1;
  // Strap: pull-down, tied high, or tied to the indicator net
  assign strapLevel = (strapMode == 2'h2) ? chargeModeNet : strapMode[0];
  // One reading every 16 clocks; data is scrambled between readings
  always @(posedge clk_sys) begin
    divCnt <= divCnt + 4'h1;
    sampleValid <= (divCnt == 4'hf);
    sampleMv <= (divCnt == 4'hf) ? tempMv : ~tempMv;
  end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch %0t %s", $time, m); end end
module tb_top;
  localparam int SEC = 20 * bts_pkg::CYC_PER_TICK;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic sensorIsSwitch = 1'b0;
  logic master_reset_n = 1'b1;
  logic rate_select_0 = 1'b0;
  logic rate_select_1 = 1'b0;
  logic fastRequest = 1'b0;
  logic fastEnd = 1'b0;
  logic [12:0] tempMv = 13'h0686;
  logic [1:0] strapMode = 2'h0;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  wire logic sampleValid, termination_select, charge_mode_indicator, cmnProbeOut, cmnProbeOe;
  wire logic hotShutdown, coldCharge, toppingActive, maintActive, fastActive, startFast;
  wire logic slopeTerminate, voltSlopeEn, tempSlopeEn, selectDone;
  wire logic [12:0] sampleMv;
  // Short time constants keep the run within budget
  bts_supervisor #(.SECOND_CYC(20), .RESET_CYC(5), .TOPPING_SEC(3), .HIST_DEPTH(4)) uut (
    .clk_sys, .rst_b, .sampleValid, .sampleMv, .sensorIsSwitch, .master_reset_n,
    .termination_select, .charge_mode_indicator, .rate_select_0, .rate_select_1,
    .fastRequest, .fastEnd, .cmnProbeOut, .cmnProbeOe, .hotShutdown, .coldCharge,
    .toppingActive, .maintActive, .fastActive, .startFast, .slopeTerminate,
    .voltSlopeEn, .tempSlopeEn, .selectDone);
  bts_sensor_model u_sensor (.clk_sys, .tempMv, .strapMode, .cmnProbeOe, .cmnProbeOut,
    .chargeModeNet(charge_mode_indicator), .strapLevel(termination_select),
    .sampleValid, .sampleMv);
  // Square clock, half high, well inside the allowed duty band
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic start(input logic [1:0] mode);
    int oeCyc;
    oeCyc = 0;
    strapMode = mode;
    rst_b = 1'b0;
    cyc_n(16);
    rst_b = 1'b1;
    // The indicator is pulled low for exactly one probe phase
    for (int i = 0; i < 1000 && selectDone !== 1'b1; i++) begin
      cyc_n(1);
      if (cmnProbeOe === 1'b1) oeCyc++;
    end
    `CHK(selectDone, 1'b1, "strap capture")
    `CHK(oeCyc, int'(bts_pkg::PROBE_US * bts_pkg::CYC_PER_TICK), "probe length")
    `CHK(cmnProbeOut, 1'b0, "probe level")
  endtask
  task automatic wait_start();
    for (int i = 0; i < 2 * SEC && startFast !== 1'b1; i++) cyc_n(1);
    `CHK({startFast, fastActive}, 2'h3, "start pulse")
  endtask
  task automatic t_strap_hot();
    for (int i = 0; i < 3; i++) begin
      start(i[1:0]);
      `CHK({voltSlopeEn, tempSlopeEn}, (i == 0) ? 2'h2 : (i == 1) ? 2'h3 : 2'h1, "strap")
    end
    tempMv = 13'h03a3;
    cyc_n(40);
    `CHK(hotShutdown, 1'b0, "hot edge")
    tempMv = 13'h03a1;
    cyc_n(40);
    `CHK(hotShutdown, 1'b1, "hot trip")
    tempMv = 13'h0686;
    master_reset_n = 1'b0;
    // Too short to count as a master reset
    cyc_n(60);
    master_reset_n = 1'b1;
    cyc_n(400);
    `CHK(hotShutdown, 1'b1, "latch held")
    master_reset_n = 1'b0;
    cyc_n(200);
    master_reset_n = 1'b1;
    cyc_n(700);
    `CHK({hotShutdown, selectDone}, 2'h1, "master reset clears")
    $display("test strap_hot done");
  endtask
  task automatic t_cold();
    start(2'h1);
    tempMv = 13'h0961;
    cyc_n(40);
    fastRequest = 1'b1;
    cyc_n(2);
    fastRequest = 1'b0;
    `CHK({toppingActive, fastActive, coldCharge}, 3'h5, "cold start")
    cyc_n(SEC * 3 / 2);
    `CHK(toppingActive, 1'b1, "topping holds")
    cyc_n(2 * SEC);
    `CHK({maintActive, coldCharge}, 2'h3, "maintenance")
    tempMv = 13'h0960;
    wait_start();
    $display("test cold done");
  endtask
  task automatic t_slope();
    logic [12:0] step;
    for (int r = 0; r < 2; r++) begin
      rate_select_0 = r[0];
      rate_select_1 = r[0];
      start(2'h2);
      tempMv = 13'h0800;
      cyc_n(40);
      fastRequest = 1'b1;
      wait_start();
      fastRequest = 1'b0;
      for (int s = 0; s < 14; s++) begin
        if (s == 8) `CHK(slopeTerminate, 1'b0, "below threshold")
        step = (r == 1) ? 13'h0006 : 13'h0009;
        if (s >= 8) step = step + 13'h0001;
        tempMv = tempMv - step;
        cyc_n(SEC);
      end
      `CHK({slopeTerminate, fastActive}, 2'h2, "slope end")
    end
    $display("test slope done");
  endtask
  task automatic t_switch();
    sensorIsSwitch = 1'b1;
    start(2'h0);
    tempMv = 13'h0385;
    cyc_n(40);
    `CHK(hotShutdown, 1'b0, "switch ignores hot")
    tempMv = 13'h1068;
    cyc_n(40);
    `CHK(hotShutdown, 1'b0, "switch edge")
    // A switch has no cold range, so the request goes straight to fast
    fastRequest = 1'b1;
    wait_start();
    fastRequest = 1'b0;
    fastEnd = 1'b1;
    cyc_n(2);
    fastEnd = 1'b0;
    `CHK({fastActive, coldCharge, slopeTerminate}, 3'h0, "fast end")
    tempMv = 13'h1069;
    cyc_n(40);
    `CHK(hotShutdown, 1'b1, "switch open")
    $display("test switch done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    t_strap_hot();
    t_cold();
    t_slope();
    t_switch();
    summarize();
  end
  // Hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      summarize();
    end
  end
endmodule
`default_nettype wire
